/* logic/ddr_sram_front_pkg.sv */
// constants and carrier types for the burst sram command and clock front end
// assumes one input clock pair (true and inverted) and an optional output clock pair
package ddr_sram_front_pkg;
   localparam int DATA_W   = 18;  // word width on the data pins
   localparam int PAIR_AW  = 3;   // address of one two-word burst
   localparam int BURST_N  = 2;   // words moved per load strobe
   localparam int DEPTH    = BURST_N << PAIR_AW;
   localparam int REF_CLK_MHZ = 100;
   // output clock counted as absent after this long without an edge
   localparam int NO_OUT_CLK_NS = 200;
   localparam int NO_OUT_CLK_CYC = (NO_OUT_CLK_NS * REF_CLK_MHZ) / 1000;
   localparam logic [7:0] NO_OUT_CLK_CNT = 8'(NO_OUT_CLK_CYC);
   localparam logic SINGLE_RST = 1'b1;   // assume single clock until output clock seen
   localparam logic RW_READ    = 1'b1;   // read/write select level meaning read

   typedef struct packed {
      logic [DATA_W-1:0] word1;
      logic [DATA_W-1:0] word0;
   } burst_t;

   typedef struct packed {
      logic               load_strobe_n;
      logic               rw_sel;
      logic [PAIR_AW-1:0] addr;
   } cmd_t;
endpackage : ddr_sram_front_pkg

/* logic/ddr_sram_clock_command_port.sv */
// command decode, ddr write capture, read launch and echo clock of a burst sram
// assumes commands are synchronous to i_ref_clk (the input clock, its falling edge
// standing for the inverted input clock) and i_out_clk is the output clock pair
`timescale 1ns/100ps
module ddr_sram_clock_command_port
   import ddr_sram_front_pkg::*;
(
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst,
   input  wire logic               i_out_clk,
   input  wire cmd_t               i_cmd,
   input  wire logic [DATA_W-1:0]  i_dq,
   output logic      [DATA_W-1:0]  o_dq,
   output logic                    o_dq_oe_n,
   output logic                    o_echo_clk,
   output logic                    o_echo_clk_n,
   output logic                    o_single_clk_mode
);

   logic [DATA_W-1:0]  mem_q [0:DEPTH-1];
   logic               accept;
   logic               wr_pend_q;
   logic               wr_data_q;
   logic [PAIR_AW-1:0] wr_addr_q;
   logic [PAIR_AW-1:0] wr_cm_addr_q;
   logic [DATA_W-1:0]  wr_w0_q;
   logic [DATA_W-1:0]  wr_w1_q;
   burst_t             rd_pair_q;
   logic               rd_tog_q;
   logic               rd_k_go_q;
   logic               k_drv_q;
   logic [DATA_W-1:0]  kq_pos_q;
   logic [DATA_W-1:0]  kq_neg_q;
   logic               single_q;
   logic [7:0]         idle_cnt_q;
   logic               alive_s1_q;
   logic               alive_s2_q;
   logic               alive_s3_q;
   logic               alive_edge;
   // output clock domain
   logic               c_rst_s1_q;
   logic               c_rst_q;
   logic               c_alive_q;
   logic               c_tog_s1_q;
   logic               c_tog_s2_q;
   logic               c_tog_s3_q;
   logic               c_new;
   burst_t             c_pair_q;
   logic               c_drv_q;
   logic [DATA_W-1:0]  cq_pos_q;
   logic [DATA_W-1:0]  cq_neg_q;

   // a load strobe low on a rising edge defines the bus cycle
   assign accept = !i_cmd.load_strobe_n;

   // write command: address now, word0 next rise, word1 on the following fall
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_pend_q <= 1'b0;
         wr_data_q <= 1'b0;
      end else begin
         wr_pend_q <= accept && (i_cmd.rw_sel != RW_READ);
         wr_data_q <= wr_pend_q;
      end
   end

   // write address and first data word, captured on the rising edge
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_addr_q    <= '0;
         wr_cm_addr_q <= '0;
         wr_w0_q      <= '0;
      end else begin
         if (accept) begin
            wr_addr_q <= i_cmd.addr;
         end
         if (wr_pend_q) begin
            wr_w0_q      <= i_dq;
            wr_cm_addr_q <= wr_addr_q;
         end
      end
   end

   // second word on the inverted clock edge gives double rate capture
   always_ff @(negedge i_ref_clk) begin
      if (wr_data_q) begin
         wr_w1_q <= i_dq;
      end
   end

   // commit both words of the burst together, read a full burst at once
   always_ff @(posedge i_ref_clk) begin
      if (wr_data_q) begin
         mem_q[{wr_cm_addr_q, 1'b0}] <= wr_w0_q;
         mem_q[{wr_cm_addr_q, 1'b1}] <= wr_w1_q;
      end
   end

   // read command: fetch the burst and hand it to both launch paths, live or parked
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rd_pair_q <= '0;
         rd_tog_q  <= 1'b0;
         rd_k_go_q <= 1'b0;
      end else begin
         rd_k_go_q <= 1'b0;
         if (accept && (i_cmd.rw_sel == RW_READ)) begin
            rd_pair_q.word0 <= mem_q[{i_cmd.addr, 1'b0}];
            rd_pair_q.word1 <= mem_q[{i_cmd.addr, 1'b1}];
            rd_tog_q        <= !rd_tog_q;
            rd_k_go_q       <= 1'b1;
         end
      end
   end

   // single clock launch: word0 from the rising edge, word1 from the falling
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         k_drv_q  <= 1'b0;
         kq_pos_q <= '0;
      end else begin
         k_drv_q <= rd_k_go_q && single_q;
         if (rd_k_go_q) begin
            kq_pos_q <= rd_pair_q.word0;
         end
      end
   end

   always_ff @(negedge i_ref_clk) begin
      kq_neg_q <= rd_pair_q.word1;
   end

   // output clock presence: a free toggle in that domain, synchronised here
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         alive_s1_q <= 1'b0;
         alive_s2_q <= 1'b0;
         alive_s3_q <= 1'b0;
      end else begin
         alive_s1_q <= c_alive_q;
         alive_s2_q <= alive_s1_q;
         alive_s3_q <= alive_s2_q;
      end
   end
   assign alive_edge = alive_s2_q ^ alive_s3_q;

   // no output clock edge for the timeout means single clock mode
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         idle_cnt_q <= '0;
         single_q   <= SINGLE_RST;
      end else if (alive_edge) begin
         idle_cnt_q <= '0;
         single_q   <= 1'b0;
      end else if (idle_cnt_q >= NO_OUT_CLK_CNT) begin
         single_q <= 1'b1;
      end else begin
         idle_cnt_q <= idle_cnt_q + 8'h01;
      end
   end
   assign o_single_clk_mode = single_q;

   // reset brought into the output clock domain; stops with that clock
   always_ff @(posedge i_out_clk) begin
      c_rst_s1_q <= i_rst;
      c_rst_q    <= c_rst_s1_q;
   end

   // read toggle crossing; the burst is held steady in rd_pair_q meanwhile
   always_ff @(posedge i_out_clk) begin
      if (c_rst_q) begin
         c_alive_q  <= 1'b0;
         c_tog_s1_q <= 1'b0;
         c_tog_s2_q <= 1'b0;
         c_tog_s3_q <= 1'b0;
      end else begin
         c_alive_q  <= !c_alive_q;
         c_tog_s1_q <= rd_tog_q;
         c_tog_s2_q <= c_tog_s1_q;
         c_tog_s3_q <= c_tog_s2_q;
      end
   end
   assign c_new = c_tog_s2_q ^ c_tog_s3_q;

   // normal launch: word0 on the output clock rise, word1 on its inverted rise
   // reads closer than three output clocks apart overrun this path
   always_ff @(posedge i_out_clk) begin
      if (c_rst_q) begin
         c_drv_q  <= 1'b0;
         cq_pos_q <= '0;
         c_pair_q <= '0;
      end else begin
         c_drv_q <= c_new;
         if (c_new) begin
            c_pair_q <= rd_pair_q;
            cq_pos_q <= rd_pair_q.word0;
         end
      end
   end

   always_ff @(negedge i_out_clk) begin
      cq_neg_q <= c_pair_q.word1;
   end

   // pin mux: the clock level picks which edge's word is on the pins
   always_comb begin
      if (single_q) begin
         o_dq      = i_ref_clk ? kq_pos_q : kq_neg_q;
         o_dq_oe_n = !k_drv_q;
      end else begin
         o_dq      = i_out_clk ? cq_pos_q : cq_neg_q;
         o_dq_oe_n = !c_drv_q;
      end
   end

   // echo clock pair is the launching clock itself, so it stops with the output clock until single clock mode takes over
   assign o_echo_clk   = single_q ? i_ref_clk : i_out_clk;
   assign o_echo_clk_n = !o_echo_clk;

   property p_read_type;
      @(posedge i_ref_clk) disable iff (i_rst)
      accept && i_cmd.rw_sel |=> (rd_tog_q != $past(rd_tog_q)) && !wr_pend_q;
   endproperty
   a_read_type: assert property (p_read_type)
      else $error("read select did not start a read");

   property p_write_type;
      @(posedge i_ref_clk) disable iff (i_rst)
      accept && !i_cmd.rw_sel |=> wr_pend_q && $stable(rd_tog_q);
   endproperty
   a_write_type: assert property (p_write_type)
      else $error("write select did not start a write");

   property p_no_load_no_access;
      @(posedge i_ref_clk) disable iff (i_rst)
      !accept |=> !wr_pend_q && !rd_k_go_q;
   endproperty
   a_no_load_no_access: assert property (p_no_load_no_access)
      else $error("access started without load strobe");

   property p_write_burst;
      @(posedge i_ref_clk) disable iff (i_rst)
      wr_pend_q |=> wr_data_q ##1 (mem_q[{$past(wr_cm_addr_q), 1'b0}] == $past(wr_w0_q));
   endproperty
   a_write_burst: assert property (p_write_burst)
      else $error("first burst word not written");

   property p_second_word;
      @(posedge i_ref_clk) disable iff (i_rst)
      wr_data_q |=> mem_q[{$past(wr_cm_addr_q), 1'b1}] == $past(wr_w1_q);
   endproperty
   a_second_word: assert property (p_second_word)
      else $error("second burst word not written");

   property p_single_launch;
      @(posedge i_ref_clk) disable iff (i_rst)
      rd_k_go_q && single_q |=> k_drv_q && (kq_pos_q == $past(rd_pair_q.word0))
         ##1 (!k_drv_q || $past(rd_k_go_q));
   endproperty
   a_single_launch: assert property (p_single_launch)
      else $error("single clock read not launched");

   property p_idle_float;
      @(posedge i_ref_clk) disable iff (i_rst)
      single_q && !rd_k_go_q ##1 single_q |-> o_dq_oe_n;
   endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("data pins driven without a read");

   property p_fallback;
      @(posedge i_ref_clk) disable iff (i_rst)
      !alive_edge && (idle_cnt_q >= NO_OUT_CLK_CNT) |=> single_q;
   endproperty
   a_fallback: assert property (p_fallback)
      else $error("no single clock mode without output clock");

   property p_normal_launch;
      @(posedge i_out_clk) disable iff (c_rst_q)
      c_new |=> c_drv_q && (cq_pos_q == rd_pair_q.word0) && (c_pair_q == rd_pair_q)
         ##1 (!c_drv_q || $past(c_new));
   endproperty
   a_normal_launch: assert property (p_normal_launch)
      else $error("output clock read not launched");

   property p_echo_pair;
      @(posedge i_ref_clk) disable iff (i_rst)
      single_q |-> !o_echo_clk && o_echo_clk_n;
   endproperty
   a_echo_pair: assert property (p_echo_pair)
      else $error("echo clock pair not complementary");

endmodule : ddr_sram_clock_command_port

/* test/sram_ctl_model.sv */
// controller model: output clock source, command and write data drivers
// assumes the bench calls cmd and wdata off the clock edges
`timescale 1ns/100ps
module sram_ctl_model
   import ddr_sram_front_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_run,
   output logic                   o_out_clk,
   output cmd_t                   o_cmd,
   output logic      [DATA_W-1:0] o_dq
);
   // output clock parks low while stopped, no stray edge
   initial begin
      o_out_clk = 1'b0;
      o_cmd = '{load_strobe_n: 1'b1, rw_sel: 1'b0, addr: '0};
      o_dq = 18'h15555;
      #3;
      forever begin
         #32;
         o_out_clk = i_run ? ~o_out_clk : 1'b0;
      end
   end

   // strobe driven on a falling edge and held low across one rise only
   task automatic cmd(input logic ld_n, input logic rw, input logic [PAIR_AW-1:0] a);
      @(negedge i_ref_clk);
      o_cmd = '{load_strobe_n: ld_n, rw_sel: rw, addr: a};
      @(negedge i_ref_clk);
      o_cmd.load_strobe_n = 1'b1;
   endtask : cmd

   // two words per burst; bus scrambled after so stale data never matches
   task automatic wdata(input burst_t b);
      o_dq = b.word0;
      @(posedge i_ref_clk);
      #2.5 o_dq = b.word1;
      @(negedge i_ref_clk);
      #2.5 o_dq = ~b.word1;
   endtask : wdata
endmodule : sram_ctl_model

/* test/ddr_sram_clock_command_port_tb.sv */
// self-checking bench for the burst sram command and clock front end
// assumes sram_ctl_model drives commands, write data and the output clock
`timescale 1ns/100ps
module ddr_sram_clock_command_port_tb
   import ddr_sram_front_pkg::*;
;
   logic              i_ref_clk = 1'b0;
   logic              i_rst     = 1'b1;
   logic              run_c     = 1'b1;  // output clock runs during reset to clear its domain
   logic              i_out_clk;
   cmd_t              i_cmd;
   logic [DATA_W-1:0] i_dq;
   logic [DATA_W-1:0] o_dq;
   logic              o_dq_oe_n;
   logic              o_echo_clk;
   logic              o_echo_clk_n;
   logic              o_single_clk_mode;
   int                error_cnt  = 0;
   int                num_checks = 0;
   localparam burst_t B5 = '{word1: 18'h2a5c3, word0: 18'h1f00e};
   localparam burst_t B2 = '{word1: 18'h0ace1, word0: 18'h35a5a};
   localparam burst_t BX = '{word1: 18'h3ffff, word0: 18'h00000};

   always #5 i_ref_clk = ~i_ref_clk;

   ddr_sram_clock_command_port DUT (.i_ref_clk, .i_rst, .i_out_clk, .i_cmd, .i_dq, .o_dq,
      .o_dq_oe_n, .o_echo_clk, .o_echo_clk_n, .o_single_clk_mode);
   sram_ctl_model u_ctl (.i_ref_clk, .i_run(run_c), .o_out_clk(i_out_clk), .o_cmd(i_cmd),
      .o_dq(i_dq));

   function automatic logic [DATA_W-1:0] z(input logic b);
      return DATA_W'(b);
   endfunction : z

   task automatic end_sim();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // single mode read: oe low one k period, word0 high half, word1 low half
   task automatic rd_single(input logic [PAIR_AW-1:0] a, input burst_t b);
      u_ctl.cmd(1'b0, RW_READ, a);
      @(posedge i_ref_clk) #2.5;
      chk(z(o_dq_oe_n), z(1'b0));
      chk(o_dq, b.word0);
      @(negedge i_ref_clk) #2.5;
      chk(o_dq, b.word1);
      @(posedge i_ref_clk) #2.5;
      chk(z(o_dq_oe_n), z(1'b1));
   endtask : rd_single

   // normal read: words follow output clock level, oe low for one c period
   task automatic rd_normal(input logic [PAIR_AW-1:0] a, input burst_t b);
      int lo = 0;
      u_ctl.cmd(1'b0, RW_READ, a);
      repeat (80) begin
         @(i_ref_clk) #2.5;
         if (o_dq_oe_n === 1'b0) begin
            lo++;
            chk(o_dq, i_out_clk ? b.word0 : b.word1);
         end
      end
      chk(z(lo > 11 && lo < 14), z(1'b1));
   endtask : rd_normal

   // sampled half a step off every edge, so no race with the clock mux
   task automatic echo_chk(input logic normal);
      repeat (16) begin
         @(i_ref_clk) #2.5;
         chk(z(o_echo_clk), z(normal ? i_out_clk : i_ref_clk));
         chk(z(o_echo_clk_n), z(~(normal ? i_out_clk : i_ref_clk)));
      end
   endtask : echo_chk

   task automatic wait_mode(input logic exp, input int lim);
      int n = 0;
      while (o_single_clk_mode !== exp && n < lim) begin
         @(negedge i_ref_clk);
         n++;
      end
      chk(z(o_single_clk_mode), z(exp));
   endtask : wait_mode

   // reset long enough for three output clock rises, then that clock is parked
   task automatic sc_reset();
      repeat (20) @(negedge i_ref_clk);
      i_rst = 1'b0;
      run_c = 1'b0;
      chk(z(o_dq_oe_n), z(1'b1));
      chk(z(o_single_clk_mode), z(SINGLE_RST));
      chk(o_dq, '0);
      echo_chk(1'b0);
   endtask : sc_reset

   // two bursts written, a strobe-less cycle ignored, both read back
   // an even number of reads here keeps the parked read toggle quiet on restart
   task automatic sc_single_rw();
      u_ctl.cmd(1'b0, ~RW_READ, 3'h5);
      u_ctl.wdata(B5);
      u_ctl.cmd(1'b0, ~RW_READ, 3'h2);
      u_ctl.wdata(B2);
      u_ctl.cmd(1'b1, ~RW_READ, 3'h5);
      u_ctl.wdata(BX);
      rd_single(3'h5, B5);
      rd_single(3'h2, B2);
   endtask : sc_single_rw

   // output clock starts: normal mode, echo and read data follow it
   task automatic sc_normal();
      run_c = 1'b1;
      wait_mode(1'b0, 40);
      echo_chk(1'b1);
      rd_normal(3'h2, B2);
      rd_normal(3'h5, B5);
   endtask : sc_normal

   // output clock stops: mode holds through the timeout, then falls back
   task automatic sc_fallback();
      run_c = 1'b0;
      repeat (NO_OUT_CLK_CYC - 6) @(negedge i_ref_clk);
      chk(z(o_single_clk_mode), z(1'b0));
      wait_mode(1'b1, 20);
      rd_single(3'h5, B5);
      echo_chk(1'b0);
   endtask : sc_fallback

   initial begin
      sc_reset();
      sc_single_rw();
      sc_normal();
      sc_fallback();
      end_sim();
   end

   // watchdog well past the few microseconds the sequence needs
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
endmodule : ddr_sram_clock_command_port_tb
